// ===== verilog/trm_regs.sv
/*
 * Trim register bank for the converter cores: two timing trims, three
 * offset trims and the calibration control and status words, reached over
 * AXI4-Lite, with the trims steered to the cores by mode, calibration phase and sampled input.
 * Assumes the calibration unit runs on sys_clk and drives its inputs
 * synchronously, and that the bus master keeps the AXI4-Lite handshake.
 */
module trm_regs #(
   parameter logic [trm_pkg::TIM_W-1:0] FACT_TIM_C_AS_B = trm_pkg::FACT_TIM_C_AS_B,
   parameter logic [trm_pkg::TIM_W-1:0] FACT_TIM_B_DUAL = trm_pkg::FACT_TIM_B_DUAL,
   parameter logic [trm_pkg::OFS_W-1:0] FACT_OFS_A_INA = trm_pkg::FACT_OFS_A_INA,
   parameter logic [trm_pkg::OFS_W-1:0] FACT_OFS_A_INB = trm_pkg::FACT_OFS_A_INB,
   parameter logic [trm_pkg::OFS_W-1:0] FACT_OFS_C_INA = trm_pkg::FACT_OFS_C_INA
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [trm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [trm_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [trm_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [trm_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fg_cal_busy,
   input wire logic foreground_cal_done,
   input wire logic cal_halted_status,
   input wire logic bg_phase_c_for_b,
   input wire logic core_a_samples_b,
   input wire logic core_c_samples_b,
   input wire logic cal_ofs_we,
   input wire logic [1:0] cal_ofs_sel,
   input wire logic [trm_pkg::OFS_W-1:0] cal_ofs_val,
   output logic background_cal_enable,
   output logic background_offset_cal_enable,
   output logic offset_cal_enable,
   output logic dual_channel_mode,
   output logic [trm_pkg::TIM_W-1:0] core_b_sample_trim,
   output logic core_b_trim_valid,
   output logic [trm_pkg::TIM_W-1:0] core_c_sample_trim,
   output logic core_c_trim_valid,
   output logic [trm_pkg::OFS_W-1:0] core_a_offset,
   output logic [trm_pkg::OFS_W-1:0] core_c_offset,
   output logic core_c_offset_valid
);
   import trm_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [NUM_TIM-1:0][TIM_W-1:0] tim;
   logic [NUM_OFS-1:0][OFS_REG_W-1:0] ofs;
   logic [CTRL_W-1:0] ctrl;

   // ---------------------------------------------------------------
   // Write channel capture
   // ---------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [IDX_W-1:0] aw_idx;
   logic [15:0] w_data;
   logic [1:0] w_strb;
   logic do_write;

   // Address and data may arrive in either order; each is held until both are in
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Capture the address word
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         aw_idx <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // Capture the data word; only the two low lanes carry register bits
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata[15:0];
         w_strb <= s_axi_wstrb[1:0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Write decode and guards
   // ---------------------------------------------------------------
   logic [NUM_TIM-1:0] wr_tim_hit;
   logic [NUM_OFS-1:0] wr_ofs_hit;
   logic wr_ctrl_hit;
   logic wr_stat_hit;
   logic wr_mapped;
   logic wr_blocked;
   logic [NUM_TIM-1:0] tim_we;
   logic [NUM_OFS-1:0] ofs_we;
   logic bg_both;

   assign bg_both = ctrl[CTRL_BG] && ctrl[CTRL_BGOS];
   assign wr_ctrl_hit = (aw_idx == IDX_CAL_CONTROL);
   assign wr_stat_hit = (aw_idx == IDX_CAL_STATUS);
   assign wr_mapped = (|wr_tim_hit) || (|wr_ofs_hit) || wr_ctrl_hit || wr_stat_hit;
   // Offset writes racing the calibration engine are refused, not merged
   assign wr_blocked = (|wr_ofs_hit) && (fg_cal_busy || bg_both);

   // One decode and write enable per trim entry
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIM; gi++) begin : g_tim
         assign wr_tim_hit[gi] = (aw_idx == TIM_IDX[gi]);
         assign tim_we[gi] = do_write && wr_tim_hit[gi] && w_strb[0];
         // Timing trim: factory value after reset, then software owned
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               tim[gi] <= (gi == TIM_B_DUAL) ? FACT_TIM_B_DUAL : FACT_TIM_C_AS_B;
            end else if (tim_we[gi]) begin
               tim[gi] <= w_data[TIM_W-1:0];
            end
         end
      end
      for (gi = 0; gi < NUM_OFS; gi++) begin : g_ofs
         logic cal_hit;
         assign wr_ofs_hit[gi] = (aw_idx == OFS_IDX[gi]);
         assign ofs_we[gi] = do_write && wr_ofs_hit[gi] && !wr_blocked;
         assign cal_hit = cal_ofs_we && (cal_ofs_sel == 2'(gi));
         // Calibration result wins over a software write in the same cycle
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               ofs[gi] <= {OFS_RSV_RESET, fact_ofs_const(gi)};
            end else if (cal_hit) begin
               ofs[gi][OFS_W-1:0] <= cal_ofs_val;
            end else if (ofs_we[gi]) begin
               if (w_strb[0]) begin
                  ofs[gi][7:0] <= w_data[7:0];
               end
               if (w_strb[1]) begin
                  ofs[gi][15:8] <= w_data[15:8];
               end
            end
         end
      end
   endgenerate

   // Factory offset by entry, as a constant for the reset branch
   function automatic logic [OFS_W-1:0] fact_ofs_const(input int e);
      if (e == OFS_A_INA) begin
         return FACT_OFS_A_INA;
      end else if (e == OFS_A_INB) begin
         return FACT_OFS_A_INB;
      end
      return FACT_OFS_C_INA;
   endfunction

   // Calibration control word
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= CTRL_RESET;
      end else if (do_write && wr_ctrl_hit && w_strb[0]) begin
         ctrl <= w_data[CTRL_W-1:0];
      end
   end

   // Write response: refused offsets give SLVERR, holes give DECERR
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= !wr_mapped ? RESP_DECERR : (wr_blocked ? RESP_SLVERR : RESP_OKAY);
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [IDX_W-1:0] ar_idx;
   logic rd_take;
   logic rd_ofs_hit;
   logic rd_blocked;
   logic rd_mapped;
   logic [DATA_W-1:0] rd_word;

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign ar_idx = s_axi_araddr[ADDR_W-1:2];
   assign rd_ofs_hit = (ar_idx == OFS_IDX[0]) || (ar_idx == OFS_IDX[1]) || (ar_idx == OFS_IDX[2]);
   // Offsets are unsettled until calibration reports a safe point
   assign rd_blocked = rd_ofs_hit && ((ctrl[CTRL_OS] && !ctrl[CTRL_BGOS] && !foreground_cal_done)
                                      || (bg_both && !cal_halted_status));
   assign rd_mapped = rd_ofs_hit || (ar_idx == TIM_IDX[0]) || (ar_idx == TIM_IDX[1])
                      || (ar_idx == IDX_CAL_CONTROL) || (ar_idx == IDX_CAL_STATUS);

   // Read data selection; narrow registers sit in the low bits
   always_comb begin
      rd_word = '0;
      if (ar_idx == TIM_IDX[0]) begin
         rd_word = {24'h00_0000, tim[0]};
      end else if (ar_idx == TIM_IDX[1]) begin
         rd_word = {24'h00_0000, tim[1]};
      end else if (ar_idx == OFS_IDX[0]) begin
         rd_word = {16'h0000, ofs[0]};
      end else if (ar_idx == OFS_IDX[1]) begin
         rd_word = {16'h0000, ofs[1]};
      end else if (ar_idx == OFS_IDX[2]) begin
         rd_word = {16'h0000, ofs[2]};
      end else if (ar_idx == IDX_CAL_CONTROL) begin
         rd_word = {28'h000_0000, ctrl};
      end else if (ar_idx == IDX_CAL_STATUS) begin
         rd_word = {29'h0000_0000, cal_halted_status, foreground_cal_done, fg_cal_busy};
      end
   end

   // Read response, one cycle after the address is taken
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= !rd_mapped ? RESP_DECERR : (rd_blocked ? RESP_SLVERR : RESP_OKAY);
         s_axi_rdata <= (rd_blocked || !rd_mapped) ? '0 : rd_word;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Trim steering to the cores
   // ---------------------------------------------------------------
   assign background_cal_enable = ctrl[CTRL_BG];
   assign background_offset_cal_enable = ctrl[CTRL_BGOS];
   assign offset_cal_enable = ctrl[CTRL_OS];
   assign dual_channel_mode = ctrl[CTRL_DUAL];

   // Registered so the analog trim lines change only on clock edges
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         core_b_sample_trim <= '0;
         core_b_trim_valid <= 1'b0;
         core_c_sample_trim <= '0;
         core_c_trim_valid <= 1'b0;
         core_a_offset <= '0;
         core_c_offset <= '0;
         core_c_offset_valid <= 1'b0;
      end else begin
         core_b_sample_trim <= tim[TIM_B_DUAL];
         core_b_trim_valid <= ctrl[CTRL_DUAL];
         core_c_sample_trim <= tim[TIM_C_AS_B];
         core_c_trim_valid <= ctrl[CTRL_DUAL] && bg_phase_c_for_b;
         core_a_offset <= core_a_samples_b ? ofs[OFS_A_INB][OFS_W-1:0] : ofs[OFS_A_INA][OFS_W-1:0];
         core_c_offset <= ofs[OFS_C_INA][OFS_W-1:0];
         core_c_offset_valid <= !core_c_samples_b;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic tim_b_touched;

   // Marks the first software write to the dual timing trim
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tim_b_touched <= 1'b0;
      end else if (tim_we[TIM_B_DUAL]) begin
         tim_b_touched <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   timing_store_a: assert property (tim_we[TIM_B_DUAL] |=> ##1 core_b_sample_trim == $past(w_data[7:0], 2))
      else $error("timing trim not stored or not steered");
   trim_select_a: assert property (ctrl[CTRL_DUAL] && bg_phase_c_for_b |=> core_c_trim_valid && core_b_trim_valid)
      else $error("core C trim not active in its phase");
   factory_read_a: assert property (rd_take && ar_idx == TIM_IDX[TIM_B_DUAL] && !tim_b_touched
                                    |=> s_axi_rdata[7:0] == FACT_TIM_B_DUAL)
      else $error("factory timing value not read back");
   reserved_keep_a: assert property (cal_ofs_we && cal_ofs_sel == 2'h0 |=> ofs[0][15:12] == $past(ofs[0][15:12]))
      else $error("calibration disturbed reserved bits");
   offset_select_a: assert property (1'b1 |=> core_a_offset ==
                                     $past(core_a_samples_b ? ofs[OFS_A_INB][11:0] : ofs[OFS_A_INA][11:0]))
      else $error("wrong offset applied to core A");
   write_guard_a: assert property (do_write && wr_blocked && !cal_ofs_we
                                   |=> $stable(ofs) && s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("guarded offset write was stored");
   read_guard_a: assert property (rd_take && rd_blocked
                                  |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("guarded offset read not refused");
   cal_update_a: assert property (cal_ofs_we && cal_ofs_sel == 2'h1 |=> ofs[1][11:0] == $past(cal_ofs_val))
      else $error("calibrated offset not stored");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   write_done_c: cover property (do_write && !wr_blocked && wr_ofs_hit[OFS_C_INA] ##1 s_axi_bvalid);
   read_refused_c: cover property (rd_take && rd_blocked);
   cal_race_c: cover property (cal_ofs_we && do_write && |wr_ofs_hit);
   c_for_b_c: cover property (core_c_trim_valid);

endmodule

// ===== verilog/trm_pkg.sv
/*
 * Constants of the converter-core trim register bank: register indices,
 * field layouts, control and status bit numbers, factory trim values and bus responses.
 * Assumes a 32-bit AXI4-Lite bus on which each register takes one aligned word.
 */
package trm_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;

   // ---------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CORE_C_AS_B_TIMING = 10'h088;
   localparam logic [IDX_W-1:0] IDX_CORE_B_DUAL_TIMING = 10'h089;
   localparam logic [IDX_W-1:0] IDX_CORE_A_INA_OFFSET = 10'h08a;
   localparam logic [IDX_W-1:0] IDX_CORE_A_INB_OFFSET = 10'h08c;
   localparam logic [IDX_W-1:0] IDX_CORE_C_INA_OFFSET = 10'h08e;
   localparam logic [IDX_W-1:0] IDX_CAL_CONTROL = 10'h0a0;
   localparam logic [IDX_W-1:0] IDX_CAL_STATUS = 10'h0a1;

   // ---------------------------------------------------------------
   // Trim arrays: entry numbers and their indices
   // ---------------------------------------------------------------
   localparam int NUM_TIM = 2;
   localparam int NUM_OFS = 3;
   localparam int TIM_C_AS_B = 0;
   localparam int TIM_B_DUAL = 1;
   localparam int OFS_A_INA = 0;
   localparam int OFS_A_INB = 1;
   localparam int OFS_C_INA = 2;
   localparam logic [IDX_W-1:0] TIM_IDX [NUM_TIM] = '{IDX_CORE_C_AS_B_TIMING, IDX_CORE_B_DUAL_TIMING};
   localparam logic [IDX_W-1:0] OFS_IDX [NUM_OFS] =
      '{IDX_CORE_A_INA_OFFSET, IDX_CORE_A_INB_OFFSET, IDX_CORE_C_INA_OFFSET};

   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int TIM_W = 8;
   localparam int OFS_W = 12;
   localparam int OFS_REG_W = 16;
   localparam int RSV_W = 4;
   localparam logic [RSV_W-1:0] OFS_RSV_RESET = 4'h0;
   localparam logic [TIM_W-1:0] FACT_TIM_C_AS_B = 8'h80;
   localparam logic [TIM_W-1:0] FACT_TIM_B_DUAL = 8'h80;
   localparam logic [OFS_W-1:0] FACT_OFS_A_INA = 12'h800;
   localparam logic [OFS_W-1:0] FACT_OFS_A_INB = 12'h800;
   localparam logic [OFS_W-1:0] FACT_OFS_C_INA = 12'h800;

   // Control register bits
   localparam int CTRL_W = 4;
   localparam int CTRL_BG = 0;
   localparam int CTRL_BGOS = 1;
   localparam int CTRL_OS = 2;
   localparam int CTRL_DUAL = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

   // Status register bits
   localparam int STAT_FG_BUSY = 0;
   localparam int STAT_FOREGROUND_CAL_DONE = 1;
   localparam int STAT_HALTED = 2;

   // ---------------------------------------------------------------
   // Bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== bench/trm_regs_tb.sv
/*
 * Self-checking bench of the trim register bank: AXI4-Lite master tasks,
 * calibration-unit stimulus, steering and guard checks, random trim traffic.
 * Assumes trm_pkg and trm_regs are compiled first; default factory values.
 */
module trm_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import trm_pkg::*;

   // ---------------------------------------------------------------
   // Signals and expectation state
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_A = {IDX_CAL_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] STAT_A = {IDX_CAL_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] HOLE_A = 12'hffc;
   logic sys_clk, reset_n;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, cal_ofs_sel;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic fg_cal_busy, foreground_cal_done, cal_halted_status, bg_phase_c_for_b;
   logic core_a_samples_b, core_c_samples_b, cal_ofs_we;
   logic [OFS_W-1:0] cal_ofs_val, core_a_offset, core_c_offset;
   logic background_cal_enable, background_offset_cal_enable, offset_cal_enable, dual_channel_mode;
   logic [TIM_W-1:0] core_b_sample_trim, core_c_sample_trim;
   logic core_b_trim_valid, core_c_trim_valid, core_c_offset_valid;
   int n_mismatch, checks, cycles;
   logic [31:0] lfsr;
   logic [ADDR_W-1:0] addr_tab [5];
   logic [15:0] exp_reg [5];

   trm_regs trm_regs_inst (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .fg_cal_busy, .foreground_cal_done, .cal_halted_status,
      .bg_phase_c_for_b, .core_a_samples_b, .core_c_samples_b, .cal_ofs_we, .cal_ofs_sel,
      .cal_ofs_val, .background_cal_enable, .background_offset_cal_enable, .offset_cal_enable,
      .dual_channel_mode, .core_b_sample_trim, .core_b_trim_valid, .core_c_sample_trim,
      .core_c_trim_valid, .core_a_offset, .core_c_offset, .core_c_offset_valid);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Galois-free shift form keeps the sequence repeatable from the seed
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Byte-lane merge; timing trims (entries 0 and 1) only have lane 0
   function automatic logic [15:0] merge(input int e, input logic [15:0] old, input logic [31:0] d,
      input logic [3:0] s);
      logic [15:0] m;
      m = old;
      if (s[0]) m[7:0] = d[7:0];
      if (s[1] && e > 1) m[15:8] = d[15:8];
      return m;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge sys_clk);
         if (aw_p && s_axi_awready) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic done(input string name);
      $display("Test %s finished, mismatches so far %0d", name, n_mismatch);
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Whole run needs well under a thousand cycles; the ceiling leaves margin
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int e;
      logic [31:0] d;
      n_mismatch = 0;
      checks = 0;
      cycles = 0;
      reset_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {fg_cal_busy, foreground_cal_done, cal_halted_status, bg_phase_c_for_b} = '0;
      {core_a_samples_b, core_c_samples_b, cal_ofs_we, cal_ofs_sel, cal_ofs_val} = '0;
      lfsr = 32'hf7ae_318b;
      addr_tab = '{{IDX_CORE_C_AS_B_TIMING, 2'b00}, {IDX_CORE_B_DUAL_TIMING, 2'b00},
         {IDX_CORE_A_INA_OFFSET, 2'b00}, {IDX_CORE_A_INB_OFFSET, 2'b00}, {IDX_CORE_C_INA_OFFSET, 2'b00}};
      exp_reg = '{{8'h00, FACT_TIM_C_AS_B}, {8'h00, FACT_TIM_B_DUAL}, {OFS_RSV_RESET, FACT_OFS_A_INA},
         {OFS_RSV_RESET, FACT_OFS_A_INB}, {OFS_RSV_RESET, FACT_OFS_C_INA}};
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      // Factory values readable after reset, reserved bits zero
      chk(32'(core_b_sample_trim), 32'(FACT_TIM_B_DUAL));
      for (int k = 0; k < 5; k++) axi_rd(addr_tab[k], 32'(exp_reg[k]), RESP_OKAY);
      axi_rd(CTRL_A, 32'(CTRL_RESET), RESP_OKAY);
      done("reset");
      // Random trim traffic with random byte lanes, then a reserved-bits corner
      for (int k = 0; k < 12; k++) begin
         lfsr = next_rand(lfsr);
         e = lfsr[7:0] % 5;
         d = next_rand(lfsr);
         exp_reg[e] = merge(e, exp_reg[e], d, lfsr[11:8]);
         axi_wr(addr_tab[e], d, lfsr[11:8], RESP_OKAY);
         axi_rd(addr_tab[e], 32'(exp_reg[e]), RESP_OKAY);
         lfsr = d;
      end
      exp_reg[2] = merge(2, exp_reg[2], 32'hffff_f5a5, 4'h2);
      axi_wr(addr_tab[2], 32'hffff_f5a5, 4'h2, RESP_OKAY);
      axi_rd(addr_tab[2], 32'(exp_reg[2]), RESP_OKAY);
      // Timing trim with the upper lane set: only lane 0 may land
      exp_reg[1] = merge(1, exp_reg[1], 32'h0000_a5c3, 4'h3);
      axi_wr(addr_tab[1], 32'h0000_a5c3, 4'h3, RESP_OKAY);
      axi_rd(addr_tab[1], 32'(exp_reg[1]), RESP_OKAY);
      done("readback");
      // Steering by mode, background phase and sampled input
      for (int m = 0; m < 4; m++) begin
         axi_wr(CTRL_A, {28'h0, m[1], 3'h0}, 4'h1, RESP_OKAY);
         bg_phase_c_for_b <= m[0];
         core_a_samples_b <= m[1];
         core_c_samples_b <= m[0];
         repeat (2) @(posedge sys_clk);
         chk(32'(dual_channel_mode), 32'(m[1]));
         chk(32'(core_b_trim_valid), 32'(m[1]));
         chk(32'(core_c_trim_valid), 32'(m[1] & m[0]));
         chk(32'(core_b_sample_trim), 32'(exp_reg[1][7:0]));
         chk(32'(core_c_sample_trim), 32'(exp_reg[0][7:0]));
         chk(32'(core_a_offset), 32'(m[1] ? exp_reg[3][11:0] : exp_reg[2][11:0]));
         chk(32'(core_c_offset), 32'(exp_reg[4][11:0]));
         chk(32'(core_c_offset_valid), 32'(!m[0]));
      end
      done("steering");
      // Guards: refused writes leave the trim alone, refused reads return zero
      fg_cal_busy <= 1'b1;
      axi_wr(addr_tab[2], 32'h0000_0123, 4'h3, RESP_SLVERR);
      fg_cal_busy <= 1'b0;
      axi_rd(addr_tab[2], 32'(exp_reg[2]), RESP_OKAY);
      axi_wr(CTRL_A, 32'h0000_0003, 4'h1, RESP_OKAY);
      chk(32'({background_cal_enable, background_offset_cal_enable, offset_cal_enable}), 32'h6);
      axi_wr(addr_tab[3], 32'h0000_0456, 4'h3, RESP_SLVERR);
      axi_rd(addr_tab[3], 32'h0000_0000, RESP_SLVERR);
      cal_halted_status <= 1'b1;
      axi_rd(addr_tab[3], 32'(exp_reg[3]), RESP_OKAY);
      axi_wr(CTRL_A, 32'h0000_0004, 4'h1, RESP_OKAY);
      axi_rd(addr_tab[4], 32'h0000_0000, RESP_SLVERR);
      foreground_cal_done <= 1'b1;
      axi_rd(addr_tab[4], 32'(exp_reg[4]), RESP_OKAY);
      axi_rd(STAT_A, 32'h0000_0006, RESP_OKAY);
      done("guards");
      // Calibration-unit update of every offset entry lands in the value bits only
      for (int k = 0; k < 3; k++) begin
         lfsr = next_rand(lfsr);
         cal_ofs_sel <= 2'(k);
         cal_ofs_val <= lfsr[11:0];
         cal_ofs_we <= 1'b1;
         @(posedge sys_clk);
         cal_ofs_we <= 1'b0;
         cal_ofs_sel <= 2'h3;
         exp_reg[k + 2][11:0] = lfsr[11:0];
         axi_rd(addr_tab[k + 2], 32'(exp_reg[k + 2]), RESP_OKAY);
      end
      // Unmapped place
      axi_wr(HOLE_A, lfsr, 4'hf, RESP_DECERR);
      axi_rd(HOLE_A, 32'h0000_0000, RESP_DECERR);
      done("calibration and unmapped");
      close_out();
   end
endmodule
